// ===== verilog/pmgp_top.sv
// Configuration, routing and edge interrupts of two general-purpose pins
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "pmgp_map.svh"
module pmgp_top
#(
	parameter int ADDR_W = 16
)
(
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [15:0]       reg_wr_data,
	input  wire logic              reg_wr_en,
	input  wire logic              reg_rd_en,
	output logic      [15:0]       reg_rd_data,
	input  wire logic [1:0]        pad_in,
	output logic      [1:0]        pad_out,
	output logic      [1:0]        pad_oe,
	output logic      [1:0]        pull_up_en,
	output logic      [1:0]        pull_down_en,
	output logic      [1:0]        supply_domain,
	input  wire pmgp_pkg::pmgp_src_t src,
	output pmgp_pkg::pmgp_req_t    fn_req,
	output logic                   irq
);

	import pmgp_pkg::*;

	localparam int SRC_W = $bits(pmgp_src_t);

	pmgp_state_t           st_reg;
	pmgp_state_t           st_next;
	logic [SRC_W+1:0]      sync_q;
	logic [1:0]            pad_s;
	pmgp_src_t             src_s;

	generate
		if (ADDR_W < 16)
		begin : g_chk
			$error("pmgp_top needs at least 16 address bits");
		end
	endgenerate

	// Pins and sources arrive from other domains
	pmgp_sync
	#(
		.W (SRC_W + 2)
	)
	u_sync
	(
		.core_clk (core_clk),
		.rst      (rst),
		.d        ({src, pad_in}),
		.q        (sync_q)
	);

	assign pad_s = sync_q[1:0];
	assign src_s = pmgp_src_t'(sync_q[SRC_W+1:2]);

	// Value of an output function before polarity
	function automatic logic out_value(input logic [3:0] code,
	                                   input logic sw,
	                                   input pmgp_src_t s);
		logic v;
		v = 1'b0;
		unique case (pmgp_out_fn_t'(code))
			PMGP_OUT_SOFTWARE:  v = sw;
			PMGP_OUT_OSC_32K:   v = s.osc_32k;
			PMGP_OUT_ON_STATE:  v = s.on_state;
			PMGP_OUT_SLEEP:     v = s.sleep_state;
			PMGP_OUT_CHANGE:    v = s.state_change;
			PMGP_OUT_SCALE1:    v = s.scale1_done;
			PMGP_OUT_SCALE2:    v = s.scale2_done;
			PMGP_OUT_EXT_EN1:   v = s.ext_power_en1;
			PMGP_OUT_EXT_EN2:   v = s.ext_power_en2;
			PMGP_OUT_SYS_GOOD:  v = s.system_supply_good;
			PMGP_OUT_CONVERTER_POWER_GOOD:  v = s.converter_power_good;
			PMGP_OUT_CLK_2M:    v = s.ext_power_clk_2m;
			PMGP_OUT_AUX_RESET: v = s.aux_reset;
			default:            v = 1'b0;
		endcase
		return v;
	endfunction

	// Edge event of a pin from raw samples and its settings
	function automatic logic edge_event(input pmgp_ctrl_t c,
	                                    input logic now,
	                                    input logic prev);
		logic rise;
		logic fall;
		logic hit;
		rise = now & ~prev;
		fall = ~now & prev;
		if (c.edge_mode)
			hit = rise | fall;
		else if (c.polarity)
			hit = rise;
		else
			hit = fall;
		return hit & c.direction & c.enable;
	endfunction

	// Masked write of a control register
	function automatic pmgp_ctrl_t ctrl_write(input logic [15:0] d);
		return pmgp_ctrl_t'(d & `PMGP_CTRL_WMASK);
	endfunction

	// Register address decode
	function automatic logic hit_addr(input logic [ADDR_W-1:0] a,
	                                  input logic [15:0] ofs);
		return a == ADDR_W'(ofs);
	endfunction

	always_comb
	begin
		logic [1:0]  ev;
		logic [1:0]  clr;
		logic [15:0] req_vec;
		logic [15:0] rd;
		logic        lvl;
		logic        drive;
		ev = 2'h0;
		clr = 2'h0;
		req_vec = 16'h0000;
		rd = 16'h0000;
		lvl = 1'b0;
		drive = 1'b0;
		st_next = st_reg;

		// Register writes
		if (reg_wr_en)
		begin
			if (hit_addr(reg_addr, `PMGP_PIN1_CTRL_OFS))
				st_next.ctrl[0] = ctrl_write(reg_wr_data);
			if (hit_addr(reg_addr, `PMGP_PIN2_CTRL_OFS))
				st_next.ctrl[1] = ctrl_write(reg_wr_data);
			if (hit_addr(reg_addr, `PMGP_INT_CLEAR_OFS))
				clr = reg_wr_data[1:0];
			if (hit_addr(reg_addr, `PMGP_INT_ENABLE_OFS))
				st_next.int_enable = reg_wr_data[1:0];
			if (hit_addr(reg_addr, `PMGP_PIN_DATA_OFS))
				st_next.sw_out =
					reg_wr_data[`PMGP_DATA_OUT_LO +: 2];
		end

		// Per-pin behaviour from current settings
		for (int i = 0; i < 2; i++)
		begin
			ev[i] = edge_event(st_reg.ctrl[i], pad_s[i],
			                   st_reg.pad_prev[i]);
			lvl = pad_s[i] ^ ~st_reg.ctrl[i].polarity;
			st_next.level[i] = lvl;
			if (st_reg.ctrl[i].direction & st_reg.ctrl[i].enable)
				req_vec[st_reg.ctrl[i].function_select] =
					req_vec[st_reg.ctrl[i].function_select] | lvl;
			drive = out_value(st_reg.ctrl[i].function_select,
			                  st_reg.sw_out[i], src_s)
			        ^ ~st_reg.ctrl[i].polarity;
			if (~st_reg.ctrl[i].enable)
			begin
				st_next.pad_out[i] = 1'b0;
				st_next.pad_oe[i] = 1'b0;
			end
			else if (st_reg.ctrl[i].direction)
			begin
				st_next.pad_out[i] = 1'b0;
				st_next.pad_oe[i] = 1'b0;
			end
			else if (st_reg.ctrl[i].open_drain)
			begin
				st_next.pad_out[i] = 1'b0;
				st_next.pad_oe[i] = ~drive;
			end
			else
			begin
				st_next.pad_out[i] = drive;
				st_next.pad_oe[i] = 1'b1;
			end
			st_next.pull_up[i] =
				st_reg.ctrl[i].pull_select == `PMGP_PULL_UP;
			st_next.pull_down[i] =
				st_reg.ctrl[i].pull_select == `PMGP_PULL_DOWN;
			st_next.supply[i] = st_reg.ctrl[i].supply_domain;
		end
		st_next.pad_prev = pad_s;
		st_next.req = pmgp_req_t'(req_vec);

		// Sticky status: a new event wins over a clear
		st_next.status = (st_reg.status & ~clr) | ev;
		st_next.irq = |(st_next.status & st_next.int_enable);

		// Register reads, answered in the next cycle
		if (reg_rd_en)
		begin
			if (hit_addr(reg_addr, `PMGP_PIN1_CTRL_OFS))
				rd = 16'(st_reg.ctrl[0]);
			else if (hit_addr(reg_addr, `PMGP_PIN2_CTRL_OFS))
				rd = 16'(st_reg.ctrl[1]);
			else if (hit_addr(reg_addr, `PMGP_INT_STATUS_OFS))
				rd = {14'h0000, st_reg.status};
			else if (hit_addr(reg_addr, `PMGP_INT_ENABLE_OFS))
				rd = {14'h0000, st_reg.int_enable};
			else if (hit_addr(reg_addr, `PMGP_PIN_DATA_OFS))
			begin
				rd[`PMGP_DATA_OUT_LO +: 2] = st_reg.sw_out;
				rd[`PMGP_DATA_LVL_LO +: 2] = st_reg.level;
			end
			else
				rd = 16'h0000;
		end
		st_next.rd_data = rd;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			st_reg <= '0;
			st_reg.ctrl[0] <= pmgp_ctrl_t'(`PMGP_CTRL_RST);
			st_reg.ctrl[1] <= pmgp_ctrl_t'(`PMGP_CTRL_RST);
			st_reg.status <= `PMGP_STATUS_RST;
			st_reg.int_enable <= `PMGP_ENABLE_RST;
			st_reg.sw_out <= `PMGP_SWOUT_RST;
			st_reg.pull_down <= 2'h3;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign reg_rd_data   = st_reg.rd_data;
	assign pad_out       = st_reg.pad_out;
	assign pad_oe        = st_reg.pad_oe;
	assign pull_up_en    = st_reg.pull_up;
	assign pull_down_en  = st_reg.pull_down;
	assign supply_domain = st_reg.supply;
	assign fn_req        = st_reg.req;
	assign irq           = st_reg.irq;

endmodule

// ===== verilog/pmgp_map.svh
// Register offsets, field positions, reset values and masks of the pin block
`ifndef PMGP_MAP_SVH
`define PMGP_MAP_SVH

// Register offsets
`define PMGP_PIN1_CTRL_OFS   16'h4038
`define PMGP_PIN2_CTRL_OFS   16'h4039
`define PMGP_INT_STATUS_OFS  16'h4040
`define PMGP_INT_CLEAR_OFS   16'h4041
`define PMGP_INT_ENABLE_OFS  16'h4042
`define PMGP_PIN_DATA_OFS    16'h4043

// Pin control field positions
`define PMGP_DIR_BIT         15
`define PMGP_PULL_HI         14
`define PMGP_PULL_LO         13
`define PMGP_EDGE_BIT        12
`define PMGP_SUPPLY_BIT      11
`define PMGP_POL_BIT         10
`define PMGP_OD_BIT          9
`define PMGP_ENA_BIT         7
`define PMGP_FN_HI           3
`define PMGP_FN_LO           0

// Pin control reset value and writable bits
`define PMGP_CTRL_RST        16'ha400
`define PMGP_CTRL_WMASK      16'hfe8f

// Pull codes
`define PMGP_PULL_NONE       2'h0
`define PMGP_PULL_DOWN       2'h1
`define PMGP_PULL_UP         2'h2

// Data register fields: software output values and input levels
`define PMGP_DATA_OUT_LO     0
`define PMGP_DATA_LVL_LO     2

// Reset values of status, enable and data
`define PMGP_STATUS_RST      2'h0
`define PMGP_ENABLE_RST      2'h0
`define PMGP_SWOUT_RST       2'h0

`endif

// ===== verilog/pmgp_pkg.sv
// Types shared by the pin configuration block
package pmgp_pkg;

	typedef struct packed {
		logic       direction;
		logic [1:0] pull_select;
		logic       edge_mode;
		logic       supply_domain;
		logic       polarity;
		logic       open_drain;
		logic       rsv8;
		logic       enable;
		logic [2:0] rsv6_4;
		logic [3:0] function_select;
	} pmgp_ctrl_t;

	// Internal sources that a pin can drive out
	typedef struct packed {
		logic osc_32k;
		logic on_state;
		logic sleep_state;
		logic state_change;
		logic scale1_done;
		logic scale2_done;
		logic ext_power_en1;
		logic ext_power_en2;
		logic system_supply_good;
		logic converter_power_good;
		logic ext_power_clk_2m;
		logic aux_reset;
	} pmgp_src_t;

	// Input function requests; bit position equals function code
	typedef struct packed {
		logic hw_ctrl2_long;
		logic hw_ctrl1_long;
		logic hw_ctrl2;
		logic hw_ctrl1;
		logic hw_enable2;
		logic hw_enable1;
		logic scale2_select;
		logic scale1_select;
		logic watchdog_reset;
		logic power_on;
		logic sleep_req;
		logic sleep_wake_long;
		logic sleep_wake;
		logic power_onoff;
		logic plain_in;
		logic plain_in_long;
	} pmgp_req_t;

	typedef enum logic [3:0] {
		PMGP_OUT_SOFTWARE   = 4'h0,
		PMGP_OUT_OSC_32K    = 4'h1,
		PMGP_OUT_ON_STATE   = 4'h2,
		PMGP_OUT_SLEEP      = 4'h3,
		PMGP_OUT_CHANGE     = 4'h4,
		PMGP_OUT_SCALE1     = 4'h8,
		PMGP_OUT_SCALE2     = 4'h9,
		PMGP_OUT_EXT_EN1    = 4'ha,
		PMGP_OUT_EXT_EN2    = 4'hb,
		PMGP_OUT_SYS_GOOD   = 4'hc,
		PMGP_OUT_CONVERTER_POWER_GOOD   = 4'hd,
		PMGP_OUT_CLK_2M     = 4'he,
		PMGP_OUT_AUX_RESET  = 4'hf
	} pmgp_out_fn_t;

	typedef struct packed {
		pmgp_ctrl_t [1:0] ctrl;
		logic [1:0]       sw_out;
		logic [1:0]       pad_prev;
		logic [1:0]       status;
		logic [1:0]       int_enable;
		logic             irq;
		logic [15:0]      rd_data;
		logic [1:0]       pad_out;
		logic [1:0]       pad_oe;
		logic [1:0]       pull_up;
		logic [1:0]       pull_down;
		logic [1:0]       supply;
		logic [1:0]       level;
		pmgp_req_t        req;
	} pmgp_state_t;

endpackage

// ===== verilog/pmgp_sync.sv
// Two-stage synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
module pmgp_sync
#(
	parameter int W = 1
)
(
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [1:0][W-1:0] stage_reg;
	logic [1:0][W-1:0] stage_next;

	generate
		if (W < 1)
		begin : g_chk
			$error("pmgp_sync width must be at least one");
		end
	endgenerate

	always_comb
	begin
		stage_next[0] = d;
		stage_next[1] = stage_reg[0];
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			stage_reg <= '0;
		else
			stage_reg <= stage_next;
	end

	assign q = stage_reg[1];

endmodule

// ===== sim/pmgp_props.sv
// Checker of the pin block outputs against its control registers
`timescale 1ns/1ps
module pmgp_props
	import pmgp_pkg::*;
#(
	parameter int ADDR_W = 16
)
(
	input wire logic              core_clk,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [15:0]       reg_wr_data,
	input wire logic              reg_wr_en,
	input wire logic              reg_rd_en,
	input wire logic [15:0]       reg_rd_data,
	input wire logic [1:0]        pad_out,
	input wire logic [1:0]        pad_oe,
	input wire logic [1:0]        pull_up_en,
	input wire logic [1:0]        pull_down_en,
	input wire logic [1:0]        supply_domain,
	input wire pmgp_pkg::pmgp_req_t fn_req
);
	logic [15:0] c1_reg;
	logic [15:0] c1d_reg;
	logic [15:0] c2_reg;
	logic [15:0] c2d_reg;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Shadow copies of both control registers, and one cycle later
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			c1_reg  <= 16'ha400;
			c1d_reg <= 16'ha400;
			c2_reg  <= 16'ha400;
			c2d_reg <= 16'ha400;
		end
		else
		begin
			if (reg_wr_en && reg_addr == 16'h4038)
				c1_reg <= reg_wr_data & 16'hfe8f;
			if (reg_wr_en && reg_addr == 16'h4039)
				c2_reg <= reg_wr_data & 16'hfe8f;
			c1d_reg <= c1_reg;
			c2d_reg <= c2_reg;
		end
	end
	chk_rd_idle_zero: assert property (!$past(reg_rd_en) |-> reg_rd_data == 16'h0)
		else $error("read data not zero outside read cycle");
	chk_ctrl1_read: assert property (reg_rd_en && reg_addr == 16'h4038
		|=> reg_rd_data == $past(c1_reg)) else $error("pin1 control readback");
	chk_ctrl2_read: assert property (reg_rd_en && reg_addr == 16'h4039
		|=> reg_rd_data == $past(c2_reg)) else $error("pin2 control readback");
	chk_pull_decode: assert property (pull_up_en[0] == (c1d_reg[14:13] == 2'h2)
		&& pull_down_en[0] == (c1d_reg[14:13] == 2'h1)) else $error("pull decode");
	chk_supply_sel: assert property (supply_domain[0] == c1d_reg[11])
		else $error("supply domain select");
	chk_tristate_off: assert property (!c1d_reg[7] || c1d_reg[15] |-> !pad_oe[0])
		else $error("pin driven while disabled or input");
	chk_open_drain: assert property (c1d_reg[9] && pad_oe[0] |-> !pad_out[0])
		else $error("open drain drove high");
	chk_reserved_out: assert property (c1d_reg[15:7] == 9'h009
		&& c1d_reg[3:0] inside {4'h5, 4'h6, 4'h7}
		|-> pad_oe[0] && pad_out[0] == !c1d_reg[10]) else $error("reserved code");
	chk_fn_gate: assert property (!(c1d_reg[15] && c1d_reg[7])
		&& !(c2d_reg[15] && c2d_reg[7]) |-> fn_req == 16'h0)
		else $error("input function without input pin");
endmodule
bind pmgp_top pmgp_props #(.ADDR_W(ADDR_W)) u_props (.core_clk(core_clk),
	.rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
	.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
	.pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pull_up_en),
	.pull_down_en(pull_down_en), .supply_domain(supply_domain),
	.fn_req(fn_req));

// ===== sim/pmgp_pad_model.sv
// Board-side model of the two pins: drivers, pulls and floating level
`timescale 1ns/1ps
module pmgp_pad_model
(
	input  wire logic       core_clk,
	input  wire logic [1:0] pad_out,
	input  wire logic [1:0] pad_oe,
	input  wire logic [1:0] pull_up_en,
	input  wire logic [1:0] pull_down_en,
	input  wire logic [1:0] ext_en,
	input  wire logic [1:0] ext_val,
	output logic      [1:0] pad_in
);
	logic flip = 1'b0;
	// A floating pin shows a level that changes every cycle
	always @(posedge core_clk)
		flip <= ~flip;
	always_comb
		for (int i = 0; i < 2; i++)
			pad_in[i] = pad_oe[i] ? pad_out[i] :
				ext_en[i] ? ext_val[i] :
				pull_up_en[i] ? 1'b1 : pull_down_en[i] ? 1'b0 : flip;
endmodule

// ===== sim/pmgp_top_tb_top.sv
// Self-checking bench of the pin configuration block
`timescale 1ns/1ps
module pmgp_top_tb_top;
	import pmgp_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] reg_addr = 16'h0;
	logic [15:0] reg_wr_data = 16'h0;
	logic        reg_wr_en = 1'b0;
	logic        reg_rd_en = 1'b0;
	logic [15:0] reg_rd_data;
	logic [1:0]  pad_in, pad_out, pad_oe, pull_up_en, pull_down_en, supply_domain;
	logic [1:0]  ext_en = 2'h0;
	logic [1:0]  ext_val = 2'h0;
	pmgp_src_t   src = '0;
	pmgp_req_t   fn_req;
	logic        irq;
	int          n_fail = 0;
	int          tests_run = 0;
	// Rows: control word, sources, then oe, out, pull-up, pull-down, supply
	localparam logic [32:0] ROWS [14] = '{
		{16'ha400, 12'h000, 5'b00010}, {16'h0480, 12'h000, 5'b10000},
		{16'h0080, 12'h000, 5'b11000}, {16'h0481, 12'h800, 5'b11000},
		{16'h048f, 12'h001, 5'b11000}, {16'h048c, 12'hff7, 5'b10000},
		{16'h0685, 12'hfff, 5'b10000}, {16'h0280, 12'h000, 5'b00000},
		{16'h4880, 12'h000, 5'b11101}, {16'h6480, 12'h000, 5'b10000},
		{16'h8480, 12'h000, 5'b00000}, {16'h0400, 12'h000, 5'b00000},
		{16'h2480, 12'h000, 5'b10010}, {16'h0486, 12'hfff, 5'b10000}};
	always #5 core_clk = ~core_clk;
	pmgp_top uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en), .supply_domain(supply_domain),
		.src(src), .fn_req(fn_req), .irq(irq));
	pmgp_pad_model u_pads (.core_clk(core_clk), .pad_out(pad_out),
		.pad_oe(pad_oe), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
		.ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
	task automatic finish_test();
		if (n_fail == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wr_data <= d;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
		#1;
		check(reg_rd_data, exp);
	endtask
	initial
	begin
		#200000;
		n_fail++;
		finish_test();
	end
	initial
	begin
		wait_n(4);
		rst <= 1'b0;
		check(pull_down_en, 16'h3);
		check(pad_oe, 16'h0);
		rd(16'h4038, 16'ha400);
		rd(16'h4039, 16'ha400);
		rd(16'h4041, 16'h0);
		rd(16'h4044, 16'h0);
		wr(16'h4039, 16'hffff);
		rd(16'h4039, 16'hfe8f);
		wr(16'h4039, 16'ha400);
		for (int i = 0; i < 14; i++)
		begin
			src <= ROWS[i][16:5];
			wr(16'h4038, ROWS[i][32:17]);
			wait_n(5);
			check(pad_oe[0], ROWS[i][4]);
			if (ROWS[i][4])
				check(pad_out[0], ROWS[i][3]);
			check({pull_up_en[0], pull_down_en[0]}, ROWS[i][2:1]);
			check(supply_domain[0], ROWS[i][0]);
		end
		ext_en <= 2'h1;
		ext_val <= 2'h0;
		wr(16'h4038, 16'ha480);
		wr(16'h4042, 16'h0001);
		wr(16'h4041, 16'h0003);
		wait_n(5);
		check(irq, 16'h0);
		ext_val <= 2'h1;
		wait_n(5);
		check(irq, 16'h1);
		rd(16'h4040, 16'h1);
		wr(16'h4041, 16'h0001);
		ext_val <= 2'h0;
		wait_n(5);
		check(irq, 16'h0);
		wr(16'h4038, 16'ha080);
		ext_val <= 2'h1;
		wait_n(5);
		check(irq, 16'h0);
		ext_val <= 2'h0;
		wait_n(5);
		check(irq, 16'h1);
		wr(16'h4041, 16'h0001);
		wr(16'h4038, 16'hb480);
		ext_val <= 2'h1;
		wait_n(5);
		check(irq, 16'h1);
		wr(16'h4041, 16'h0001);
		ext_val <= 2'h0;
		wait_n(5);
		check(irq, 16'h1);
		wr(16'h4042, 16'h0000);
		wait_n(2);
		check(irq, 16'h0);
		rd(16'h4040, 16'h1);
		ext_val <= 2'h1;
		for (int n = 0; n < 16; n++)
		begin
			wr(16'h4038, 16'ha480 | n[15:0]);
			wait_n(5);
			check(fn_req, 16'h1 << n);
		end
		wr(16'h4039, 16'h0c80);
		wr(16'h4043, 16'h0002);
		wait_n(5);
		check(pad_oe[1], 1'b1);
		check(pad_out[1], 1'b1);
		check(supply_domain[1], 1'b1);
		check({pull_up_en[1], pull_down_en[1]}, 2'h0);
		rd(16'h4043, 16'h000e);
		rd(16'h4042, 16'h0000);
		rst <= 1'b1;
		wait_n(2);
		rst <= 1'b0;
		rd(16'h4038, 16'ha400);
		finish_test();
	end
endmodule
